// ### pkg/eewl_pkg.sv
// eewl_pkg: constants for the data EEPROM write-latch programmer
// assumes a 10 MHz aclk and an AXI4-Lite register port with 32-bit data
package eewl_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    // programming cycle duration in microseconds and its cycle count
    localparam int unsigned PROG_TIME_US    = 5000;
    localparam int unsigned PROG_CYCLES     = (PROG_TIME_US * (CLK_HZ / 1_000_000));
    // erase takes the first half of the cycle, programming the second
    localparam int unsigned ERASE_DIV       = 2;
    // register byte addresses
    localparam logic [11:0] CTRL_ADDR       = 12'h000;
    localparam logic [11:0] STATUS_ADDR     = 12'h004;
    localparam logic [11:0] CPU_ADDR        = 12'h008;
    localparam logic [11:0] MEM_BASE        = 12'h400;
    localparam logic [11:0] MEM_MASK        = 12'hC00;
    // control register fields
    localparam int unsigned CTRL_PGM_BIT    = 0;
    localparam int unsigned CTRL_LAT_BIT    = 1;
    localparam int unsigned CTRL_ITE_BIT    = 2;
    localparam logic [2:0]  CTRL_RESET      = 3'h0;
    // cpu mode register fields
    localparam int unsigned CPU_IMASK_BIT   = 0;
    localparam int unsigned CPU_WAIT_BIT    = 1;
    localparam int unsigned CPU_HALT_BIT    = 2;
    localparam int unsigned CPU_ISR_BIT     = 3;
    // status register fields
    localparam int unsigned ST_IRQ_BIT      = 0;
    localparam int unsigned ST_WAIT_BIT     = 1;
    localparam int unsigned ST_HALT_BIT     = 2;
    localparam int unsigned ST_ERASE_BIT    = 3;
    localparam int unsigned ST_DRIVE_BIT    = 4;
    localparam int unsigned ST_FETCH_BIT    = 5;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam logic [1:0]  RESP_DECERR     = 2'h3;
    localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
    typedef enum logic [1:0]
    {
        EEWL_IDLE  = 2'h0,
        EEWL_ERASE = 2'h1,
        EEWL_PROG  = 2'h2
    } eewl_state_t;
endpackage

// ### design/eewl_top.sv
// eewl_top: 256-byte data EEPROM with 16 row latches, timed row programming
// assumes a single CPU-side master on AXI4-Lite; one clock, synchronous reset
//
// What this block does
// RULE1 - write-mode clear: memory reads return the addressed byte within one cycle
// RULE2 - memory serves only data reads; memory fetches flagged with ARPROT instruction fail
// RULE3 - setting write mode with program clear makes memory writes fill sixteen latches
// RULE4 - setting program writes all latched bytes, one to sixteen, in one cycle
// RULE5 - row programmed comes from the most recent write-mode memory write
// RULE6 - software keeps the row constant between cycles; only low four bits change
// RULE7 - at cycle end program and write-mode clear together; interrupt if enabled
// RULE8 - rewriting a latched byte ANDs new data into the held value
// RULE9 - latches clear only at cycle end and on write-mode falling
// RULE10 - latch contents can never be read back
// RULE11 - memory reads in write mode leave the data bus undriven
// RULE12 - memory writes outside write mode are ignored and latch nothing
// RULE13 - an aborted cycle leaves cell contents undefined; software avoids aborting
// RULE14 - wait instruction: enter wait at once if idle, else after the cycle
// RULE15 - completion interrupt wakes from wait, never from halt
// RULE16 - halt stops at once, aborting any running cycle
// RULE17 - interrupt reaches CPU only when enabled and global mask clear
// RULE18 - cycle is timed internally, erase then program chained automatically
// RULE19 - control: bit2 enable, bit1 write mode, bit0 program; upper zero; reset zero
// RULE20 - software clearing write mode only works while program is clear
// RULE21 - pending interrupt clears when CPU enters its service routine
// RULE22 - cycle length is a parameter count; program reads one throughout
`timescale 1ns/1ps
module eewl_top #(
    parameter int unsigned PROG_COUNT = eewl_pkg::PROG_CYCLES
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address and data
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // cpu side indications
    output logic             irq_q,
    output logic             wake_q
);
    localparam int unsigned CW = $clog2(PROG_COUNT + 1);
    localparam logic [CW-1:0] ERASE_END = CW'(PROG_COUNT / eewl_pkg::ERASE_DIV);
    localparam logic [CW-1:0] LAST_CNT  = CW'(PROG_COUNT - 1);

    logic [7:0]  mem_q [256];
    logic [7:0]  lat_q [16];
    logic [15:0] latv_q;
    logic [3:0]  row_q;
    logic [2:0]  ctrl_q, ctrl_d;
    logic        imask_q, imask_d, wait_q, wait_d, halt_q, halt_d, pend_q, pend_d;
    logic        wfi_q, wfi_d, drv_q, drv_d, fetch_q, fetch_d;
    logic [CW-1:0] cnt_q, cnt_d;
    eewl_pkg::eewl_state_t st_q, st_d;
    // bus registers
    logic        aw_q, w_q, aw_d, w_d;
    logic [11:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d;
    logic [3:0]  ws_q, ws_d;
    logic        bv_q, bv_d, rv_q, rv_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    logic [31:0] rd_q, rd_d;
    logic        mem_wr, lat_clr, done;

    function automatic logic is_mem(input logic [11:0] a);
        return (a & eewl_pkg::MEM_MASK) == eewl_pkg::MEM_BASE;
    endfunction

    function automatic logic [7:0] mem_idx(input logic [11:0] a);
        return a[9:2];
    endfunction

    wire wr_go = aw_q && w_q && !bv_q;
    wire rd_go = s_axi_arvalid && !rv_q;
    wire busy  = (st_q != eewl_pkg::EEWL_IDLE);

    always_comb
    begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rr_d = rr_q;
        rd_d = rd_q;
        ctrl_d = ctrl_q;
        imask_d = imask_q;
        wfi_d = wfi_q;
        halt_d = halt_q;
        pend_d = pend_q;
        drv_d = drv_q;
        fetch_d = fetch_q;
        mem_wr = 1'b0;
        lat_clr = 1'b0;
        if (s_axi_awvalid && !aw_q)
        begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q)
        begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (bv_q && s_axi_bready)
            bv_d = 1'b0;
        if (rv_q && s_axi_rready)
            rv_d = 1'b0;
        // hardware completion: its clears and its pending set win over any software write in this cycle
        done = (st_q == eewl_pkg::EEWL_PROG) && (cnt_q == LAST_CNT) && !halt_q;
        if (wr_go)
        begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = eewl_pkg::RESP_OKAY;
            if (awa_q == eewl_pkg::CTRL_ADDR && ws_q[0])
            begin
                ctrl_d[eewl_pkg::CTRL_ITE_BIT] = wd_q[eewl_pkg::CTRL_ITE_BIT];
                if (wd_q[eewl_pkg::CTRL_LAT_BIT])
                    ctrl_d[eewl_pkg::CTRL_LAT_BIT] = 1'b1;
                else if (!ctrl_q[eewl_pkg::CTRL_PGM_BIT]) // RULE20
                    ctrl_d[eewl_pkg::CTRL_LAT_BIT] = 1'b0;
                // program may start only from write mode; clearing it aborts
                if (wd_q[eewl_pkg::CTRL_PGM_BIT] && ctrl_d[eewl_pkg::CTRL_LAT_BIT])
                    ctrl_d[eewl_pkg::CTRL_PGM_BIT] = 1'b1; // RULE4
                else if (!wd_q[eewl_pkg::CTRL_PGM_BIT])
                    ctrl_d[eewl_pkg::CTRL_PGM_BIT] = 1'b0; // RULE13
            end
            else if (awa_q == eewl_pkg::CPU_ADDR && ws_q[0])
            begin
                imask_d = wd_q[eewl_pkg::CPU_IMASK_BIT];
                if (wd_q[eewl_pkg::CPU_WAIT_BIT])
                    wfi_d = 1'b1;
                if (wd_q[eewl_pkg::CPU_HALT_BIT])
                begin
                    halt_d = 1'b1; // RULE16
                    ctrl_d[eewl_pkg::CTRL_PGM_BIT] = 1'b0;
                end
                else
                    halt_d = 1'b0;
                if (wd_q[eewl_pkg::CPU_ISR_BIT])
                    pend_d = 1'b0; // RULE21
            end
            else if (is_mem(awa_q))
            begin
                // ignored outside write mode or while programming
                if (ctrl_q[eewl_pkg::CTRL_LAT_BIT] && !ctrl_q[eewl_pkg::CTRL_PGM_BIT] && ws_q[0])
                    mem_wr = 1'b1; // RULE3 RULE12
            end
            else if (awa_q != eewl_pkg::STATUS_ADDR)
                br_d = eewl_pkg::RESP_DECERR;
        end
        if (ctrl_q[eewl_pkg::CTRL_LAT_BIT] && !ctrl_d[eewl_pkg::CTRL_LAT_BIT])
            lat_clr = 1'b1; // RULE9
        if (done)
        begin
            ctrl_d[eewl_pkg::CTRL_PGM_BIT] = 1'b0; // RULE7
            ctrl_d[eewl_pkg::CTRL_LAT_BIT] = 1'b0;
            lat_clr = 1'b1; // RULE9
            if (ctrl_q[eewl_pkg::CTRL_ITE_BIT])
                pend_d = 1'b1; // RULE7
        end
        // a wfi request is consumed once wait is entered
        if (wait_d)
            wfi_d = 1'b0;
        if (rd_go)
        begin
            rv_d = 1'b1;
            rr_d = eewl_pkg::RESP_OKAY;
            rd_d = '0;
            drv_d = 1'b0;
            fetch_d = 1'b0;
            if (s_axi_araddr == eewl_pkg::CTRL_ADDR)
                rd_d = {29'h0, ctrl_q}; // RULE19
            else if (s_axi_araddr == eewl_pkg::STATUS_ADDR)
                rd_d = {26'h0, fetch_q, drv_q, st_q == eewl_pkg::EEWL_ERASE,
                        halt_q, wait_q, pend_q};
            else if (s_axi_araddr == eewl_pkg::CPU_ADDR)
                rd_d = {31'h0, imask_q};
            else if (is_mem(s_axi_araddr))
            begin
                if (s_axi_arprot[2])
                begin
                    rr_d = eewl_pkg::RESP_SLVERR; // RULE2
                    fetch_d = 1'b1;
                end
                else if (ctrl_q[eewl_pkg::CTRL_LAT_BIT])
                    drv_d = 1'b0; // RULE11 RULE10
                else
                begin
                    rd_d = {24'h0, mem_q[mem_idx(s_axi_araddr)]}; // RULE1
                    drv_d = 1'b1;
                end
            end
            else
                rr_d = eewl_pkg::RESP_DECERR;
        end
    end

    // wait is entered once the wfi request sees no running cycle
    always_comb
    begin
        wait_d = wait_q;
        if (wfi_q && !busy && !ctrl_q[eewl_pkg::CTRL_PGM_BIT])
            wait_d = 1'b1; // RULE14
        if (wait_q && pend_q)
            wait_d = 1'b0; // RULE15
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            eewl_pkg::EEWL_IDLE:
            begin
                cnt_d = '0;
                if (ctrl_q[eewl_pkg::CTRL_PGM_BIT] && !halt_q)
                    st_d = eewl_pkg::EEWL_ERASE; // RULE18
            end
            eewl_pkg::EEWL_ERASE:
            begin
                cnt_d = cnt_q + CW'(1);
                if (cnt_q == ERASE_END - CW'(1))
                    st_d = eewl_pkg::EEWL_PROG; // RULE18
            end
            eewl_pkg::EEWL_PROG:
            begin
                cnt_d = cnt_q + CW'(1);
                if (cnt_q == LAST_CNT)
                    st_d = eewl_pkg::EEWL_IDLE; // RULE22
            end
            default:
                st_d = eewl_pkg::EEWL_IDLE;
        endcase
        if (busy && (!ctrl_q[eewl_pkg::CTRL_PGM_BIT] || halt_q))
            st_d = eewl_pkg::EEWL_IDLE; // RULE13 RULE16
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
            bv_q <= 1'b0;
            br_q <= eewl_pkg::RESP_OKAY;
            rv_q <= 1'b0;
            rr_q <= eewl_pkg::RESP_OKAY;
            rd_q <= '0;
            ctrl_q <= eewl_pkg::CTRL_RESET; // RULE19
            imask_q <= 1'b1;
            wfi_q <= 1'b0;
            wait_q <= 1'b0;
            halt_q <= 1'b0;
            pend_q <= 1'b0;
            drv_q <= 1'b0;
            fetch_q <= 1'b0;
            st_q <= eewl_pkg::EEWL_IDLE;
            cnt_q <= '0;
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else
        begin
            aw_q <= aw_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rr_q <= rr_d;
            rd_q <= rd_d;
            ctrl_q <= ctrl_d;
            imask_q <= imask_d;
            wfi_q <= wfi_d;
            wait_q <= wait_d;
            halt_q <= halt_d;
            pend_q <= pend_d;
            drv_q <= drv_d;
            fetch_q <= fetch_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            irq_q <= pend_d && !imask_d; // RULE17
            wake_q <= pend_d && wait_q && !halt_d; // RULE15
        end
    end

    // latches and row: no reset needed on data, valid bits are reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn || lat_clr)
            latv_q <= '0;
        else if (mem_wr)
            latv_q[awa_q[5:2]] <= 1'b1;
        if (mem_wr)
        begin
            row_q <= awa_q[9:6]; // RULE5 RULE6
            lat_q[awa_q[5:2]] <= latv_q[awa_q[5:2]] ? (lat_q[awa_q[5:2]] & wd_q[7:0])
                                                     : wd_q[7:0]; // RULE8
        end
    end

    // cells: erase then program the latched bytes of the row only
    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < 16; i++)
        begin
            if (st_q == eewl_pkg::EEWL_ERASE && cnt_q == '0 && latv_q[i])
                mem_q[{row_q, 4'(i)}] <= eewl_pkg::ERASED_BYTE;
            else if (done && latv_q[i])
                mem_q[{row_q, 4'(i)}] <= lat_q[i]; // RULE4
        end
    end

    assign s_axi_awready = !aw_q;
    assign s_axi_wready  = !w_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rresp   = rr_q;
    assign s_axi_rdata   = rd_q;

    prog_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(st_q == eewl_pkg::EEWL_ERASE) |-> ctrl_q[eewl_pkg::CTRL_PGM_BIT] [*8]) // RULE22
        else $error("program bit dropped early");
    end_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        done |=> !ctrl_q[eewl_pkg::CTRL_PGM_BIT] && !ctrl_q[eewl_pkg::CTRL_LAT_BIT]) // RULE7
        else $error("end of cycle did not clear both bits");
    end_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        done && ctrl_q[eewl_pkg::CTRL_ITE_BIT] |=> pend_q) // RULE7
        else $error("no pending request after cycle");
    irq_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_q |-> $past(pend_d) && !$past(imask_d)) // RULE17
        else $error("interrupt while masked");
    lat_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_q[eewl_pkg::CTRL_PGM_BIT] && ctrl_q[eewl_pkg::CTRL_LAT_BIT] && !done && !halt_d
        |=> ctrl_q[eewl_pkg::CTRL_LAT_BIT]) // RULE20
        else $error("write mode cleared during programming");
    ignore_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_q[eewl_pkg::CTRL_LAT_BIT] |-> !mem_wr) // RULE12
        else $error("latched a write outside write mode");
    halt_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        halt_q |=> st_q == eewl_pkg::EEWL_IDLE) // RULE16
        else $error("cycle kept running in halt");
    wait_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        busy && !wait_q |=> !wait_q) // RULE14
        else $error("wait entered during a cycle");
    undriven_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_go && is_mem(s_axi_araddr) && ctrl_q[eewl_pkg::CTRL_LAT_BIT]
        |=> s_axi_rdata == 32'h0 && !drv_q) // RULE11
        else $error("bus driven in write mode");
endmodule

// ### bench/eewl_cpu_bfm.sv
// eewl_cpu_bfm: cpu-side axi4-lite master in front of the eeprom programmer
// assumes one clock; at most one write and one read under way at a time
`timescale 1ns/1ps
module eewl_cpu_bfm (
    // clock
    input  wire logic   aclk,
    // write channels
    output logic [11:0] s_axi_awaddr,
    output logic [2:0]  s_axi_awprot,
    output logic        s_axi_awvalid,
    input  wire logic   s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    output logic        s_axi_wvalid,
    input  wire logic   s_axi_wready,
    input  wire logic   s_axi_bvalid,
    output logic        s_axi_bready,
    // read channels
    output logic [11:0] s_axi_araddr,
    output logic [2:0]  s_axi_arprot,
    output logic        s_axi_arvalid,
    input  wire logic   s_axi_arready,
    input  wire logic   s_axi_rvalid,
    output logic        s_axi_rready
);
    initial
    begin
        {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
        {s_axi_wstrb, s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
    end

    // released payload is inverted so a stale value is never mistaken for a live one
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit ap;
        bit wp;
        bit bp;
        ap = 1'b1;
        wp = 1'b1;
        bp = 1'b1;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (bp)
        begin
            @(posedge aclk);
            if (!ap && !wp && s_axi_bvalid)
            begin
                bp = 1'b0;
                s_axi_bready <= 1'b0;
            end
            if (ap && s_axi_awready)
            begin
                ap = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (wp && s_axi_wready)
            begin
                wp = 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~d;
            end
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [2:0] p);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arprot  <= p;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        @(posedge aclk);
        while (!s_axi_arready)
            @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
        @(posedge aclk);
        while (!s_axi_rvalid)
            @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
endmodule

// ### bench/tb.sv
// tb: self-checking bench for eewl_top, cpu master model in front
// assumes the design answers on the bus and raises irq_q within the timeout
`timescale 1ns/1ps
`define CHK(nm, got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
        end \
    end
module tb;
    localparam int unsigned PC = 40;
    logic        aclk;
    logic        aresetn;
    logic [11:0] s_axi_awaddr;
    logic [2:0]  s_axi_awprot;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [11:0] s_axi_araddr;
    logic [2:0]  s_axi_arprot;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        irq_q;
    logic        wake_q;
    int          error_cnt;
    int          cmp_count;
    int          cyc;
    logic [34:0] rq[$];
    logic [1:0]  bq[$];
    logic [15:0] lf;
    logic [7:0]  d[16];
    logic [3:0]  row;
    logic [34:0] e;
    logic [1:0]  eb;

    eewl_top #(.PROG_COUNT(PC)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq_q, .wake_q);
    eewl_cpu_bfm u_cpu (.aclk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

    initial
    begin
        aclk = 1'b0;
        forever
            #50 aclk = ~aclk;
    end

    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic logic [11:0] maddr(input logic [3:0] r, input logic [3:0] l);
        return eewl_pkg::MEM_BASE | {2'h0, r, l, 2'h0};
    endfunction

    task automatic report_and_stop;
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // note the expected response, then run the transfer
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        bq.push_back(eewl_pkg::RESP_OKAY);
        u_cpu.wr(a, v);
    endtask

    task automatic rd(input logic [11:0] a, input logic [2:0] p, input logic [1:0] r,
                      input logic [31:0] v, input logic c);
        rq.push_back({c, r, v});
        u_cpu.rd(a, p);
    endtask

    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            report_and_stop();
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            e = rq.pop_front();
            `CHK("rresp", s_axi_rresp, e[33:32])
            if (e[34])
                `CHK("rdata", s_axi_rdata, e[31:0])
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            eb = bq.pop_front();
            `CHK("bresp", s_axi_bresp, eb)
        end
    end

    initial
    begin
        aresetn = 1'b0;
        lf = 16'h202C;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(eewl_pkg::CTRL_ADDR, 3'h0, eewl_pkg::RESP_OKAY, 32'h0, 1'b1);
        rd(12'h00C, 3'h0, eewl_pkg::RESP_DECERR, 32'h0, 1'b0);
        wr(eewl_pkg::CPU_ADDR, 32'h0);
        wr(eewl_pkg::CTRL_ADDR, 32'h2);
        rd(maddr(4'h0, 4'h0), 3'h0, eewl_pkg::RESP_OKAY, 32'h0, 1'b1);
        rd(eewl_pkg::STATUS_ADDR, 3'h0, eewl_pkg::RESP_OKAY, 32'h0, 1'b1);
        lf = step(lf);
        row = lf[3:0];
        // the row stays fixed while the latches fill
        for (int i = 0; i < 16; i++)
        begin
            lf = step(lf);
            d[i] = lf[7:0];
            wr(maddr(row, i[3:0]), {24'h0, d[i]});
        end
        wr(maddr(row, 4'h3), 32'h5A);
        d[3] = d[3] & 8'h5A;
        wr(eewl_pkg::CTRL_ADDR, 32'h7);
        wr(eewl_pkg::CTRL_ADDR, 32'h5);
        rd(eewl_pkg::CTRL_ADDR, 3'h0, eewl_pkg::RESP_OKAY, 32'h7, 1'b1);
        wr(eewl_pkg::CPU_ADDR, 32'h2);
        // the cycle is never cut short, so the cells are defined afterwards
        while (irq_q !== 1'b1)
            @(posedge aclk);
        repeat (2) @(posedge aclk);
        `CHK("wake_q", wake_q, 1'b1)
        wr(eewl_pkg::CPU_ADDR, 32'h8);
        repeat (2) @(posedge aclk);
        `CHK("irq_q", irq_q, 1'b0)
        rd(eewl_pkg::CTRL_ADDR, 3'h0, eewl_pkg::RESP_OKAY, 32'h4, 1'b1);
        for (int i = 0; i < 16; i++)
            rd(maddr(row, i[3:0]), 3'h0, eewl_pkg::RESP_OKAY, {24'h0, d[i]}, 1'b1);
        rd(maddr(row, 4'h0), 3'h4, eewl_pkg::RESP_SLVERR, 32'h0, 1'b0);
        wr(maddr(row, 4'h0), 32'h0);
        rd(maddr(row, 4'h0), 3'h0, eewl_pkg::RESP_OKAY, {24'h0, d[0]}, 1'b1);
        wr(eewl_pkg::CPU_ADDR, 32'h1);
        wr(eewl_pkg::CTRL_ADDR, 32'h6);
        wr(maddr(~row, 4'h5), 32'h0);
        wr(eewl_pkg::CTRL_ADDR, 32'h4);
        wr(eewl_pkg::CTRL_ADDR, 32'h6);
        wr(maddr(~row, 4'h5), {24'h0, d[7]});
        wr(eewl_pkg::CTRL_ADDR, 32'h7);
        repeat (PC + 10) @(posedge aclk);
        `CHK("irq_q", irq_q, 1'b0)
        wr(eewl_pkg::CPU_ADDR, 32'h0);
        repeat (2) @(posedge aclk);
        `CHK("irq_q", irq_q, 1'b1)
        rd(maddr(~row, 4'h5), 3'h0, eewl_pkg::RESP_OKAY, {24'h0, d[7]}, 1'b1);
        // halt in mid-erase aborts the cycle; write mode and enable stay
        wr(eewl_pkg::CTRL_ADDR, 32'h6);
        wr(maddr(row, 4'h1), {24'h0, d[2]});
        wr(eewl_pkg::CTRL_ADDR, 32'h7);
        repeat (8) @(posedge aclk);
        wr(eewl_pkg::CPU_ADDR, 32'h4);
        rd(eewl_pkg::CTRL_ADDR, 3'h0, eewl_pkg::RESP_OKAY, 32'h6, 1'b1);
        wr(eewl_pkg::CPU_ADDR, 32'h0);
        repeat (4) @(posedge aclk);
        `CHK("queue", rq.size() + bq.size(), 0)
        report_and_stop();
    end
endmodule
